// >>> cct_pkg.sv
package cct_pkg;

	// ****************************************
	// Clock and tick rates
	// ****************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FAST_HZ = 13_560_000;
	localparam int unsigned SLOW_DIV = 64;
	localparam int unsigned ACC_W = 27;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(FAST_HZ);
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
	localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);

	// ****************************************
	// Register indices, byte address is four times the index
	// ****************************************
	localparam logic [7:0] IDX_CTRL = 8'h19;
	localparam logic [7:0] IDX_RLD_HI = 8'h1a;
	localparam logic [7:0] IDX_RLD_LO = 8'h1b;
	localparam logic [7:0] IDX_CNT_HI = 8'h1c;
	localparam logic [7:0] IDX_CNT_LO = 8'h1d;
	localparam logic [7:0] IDX_SIB_CTRL = 8'h1e;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
	localparam logic [7:0] IDX_CMD = 8'h32;
	localparam logic [7:0] IDX_RUN = 8'h33;

	// ****************************************
	// Control register layout
	// ****************************************
	localparam int unsigned CTL_STOP_RX = 7;
	localparam int unsigned CTL_START_HI = 5;
	localparam int unsigned CTL_START_LO = 4;
	localparam int unsigned CTL_AUTO = 3;
	localparam int unsigned CTL_CLK_HI = 1;
	localparam int unsigned CTL_CLK_LO = 0;
	localparam logic [7:0] CTL_WMASK = 8'hbb;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Start source codes
	localparam logic [1:0] START_NONE = 2'h0;
	localparam logic [1:0] START_TX_END = 2'h1;
	localparam logic [1:0] START_TRIM = 2'h2;
	localparam logic [1:0] START_TRIM_UF = 2'h3;

	// Input clock codes
	localparam logic [1:0] CLK_FAST = 2'h0;
	localparam logic [1:0] CLK_SLOW = 2'h1;
	localparam logic [1:0] CLK_T0 = 2'h2;
	localparam logic [1:0] CLK_T1 = 2'h3;

	// ****************************************
	// Interrupt, command and run state layout
	// ****************************************
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_UNDERFLOW = 0;
	localparam int unsigned IRQ_STOPPED = 1;
	localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;
	localparam int unsigned CMD_START = 0;
	localparam int unsigned CMD_STOP = 1;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;

endpackage

// >>> cct_tick_if.sv
`timescale 1ns/100ps
interface cct_tick_if;
	logic fast_tick;
	logic slow_tick;
	modport src(output fast_tick, output slow_tick);
	modport dst(input fast_tick, input slow_tick);
endinterface

// >>> cct_tick_gen.sv
`timescale 1ns/100ps
module cct_tick_gen (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Tick enables
	cct_tick_if.src o_ticks
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [cct_pkg::ACC_W-1:0] acc;
		logic [5:0] div;
		logic fast;
		logic slow;
	} cct_tick_state_t;

	cct_tick_state_t s_r;
	cct_tick_state_t s_nxt;
	logic [cct_pkg::ACC_W-1:0] sum;

	// Fractional accumulator: ticks average the exact rate, jitter one cycle
	always_comb begin
		s_nxt = s_r;
		sum = s_r.acc + cct_pkg::ACC_STEP;
		s_nxt.fast = 1'b0;
		s_nxt.slow = 1'b0;
		if (sum >= cct_pkg::ACC_MOD) begin
			s_nxt.acc = sum - cct_pkg::ACC_MOD;
			s_nxt.fast = 1'b1;
			s_nxt.div = s_r.div + 6'h01;
			// Slow tick is the fast tick divided down
			if (s_r.div == cct_pkg::SLOW_LAST) begin
				s_nxt.slow = 1'b1;
			end
		end else begin
			s_nxt.acc = sum;
		end
	end

	// Register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_ticks.fast_tick = s_r.fast;
	assign o_ticks.slow_tick = s_r.slow;

endmodule

// >>> cct_timer.sv
// Behaviour
// - Stop-on-receive halts after first four bits
// - Trimming modes ignore stop-on-receive
// - Start source none or end of transmission
// - Trimming modes start/stop on oscillator edges
// - Auto reload restarts countdown at zero, except in trimming without underflow
// - Without auto reload stop at zero
// - Underflow sets the interrupt flag
// - Clock select picks fast or slow tick
// - Clock select cascades other timers' underflows
// - Start event loads the reload value
// - Reload writes wait for next start
// - Live count readable as two bytes
// - Sibling control register shares the layout
// - Control register sits at index 19h
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module cct_timer (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Radio events, same clock
	input wire logic i_tx_end,
	input wire logic i_rx_first4,
	// Cascade inputs, same clock
	input wire logic i_t0_underflow,
	input wire logic i_t1_underflow,
	// Slow oscillator pin
	input wire logic i_slow_osc,
	// Status outputs
	output logic o_underflow,
	output logic o_running,
	output logic [7:0] o_sibling_control,
	output logic o_irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] sib_ctrl;
		logic [15:0] reload;
		logic [15:0] count;
		logic running;
		logic underflow;
		logic [cct_pkg::IRQ_W-1:0] status;
		logic [cct_pkg::IRQ_W-1:0] mask;
		logic irq;
		logic bus_wait;
		logic [31:0] rdata;
		logic osc_s1;
		logic osc_s2;
		logic osc_s3;
		logic osc_level;
	} cct_state_t;

	localparam cct_state_t RST = '{
		ctrl: cct_pkg::CTRL_RST,
		sib_ctrl: cct_pkg::CTRL_RST,
		reload: cct_pkg::RELOAD_RST,
		count: cct_pkg::COUNT_RST,
		mask: cct_pkg::MASK_RST,
		bus_wait: 1'b1,
		default: '0
	};

	cct_state_t s_r;
	cct_state_t s_nxt;

	// ****************************************
	// Tick generator
	// ****************************************
	cct_tick_if ticks ();

	cct_tick_gen u_tick_gen (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.o_ticks(ticks.src)
	);

	// ****************************************
	// Decoded control fields
	// ****************************************
	logic [1:0] start_mode;
	logic [1:0] clk_sel;
	logic stop_rx_en;
	logic auto_en;
	logic trim;

	assign start_mode = s_r.ctrl[cct_pkg::CTL_START_HI:cct_pkg::CTL_START_LO];
	assign clk_sel = s_r.ctrl[cct_pkg::CTL_CLK_HI:cct_pkg::CTL_CLK_LO];
	assign stop_rx_en = s_r.ctrl[cct_pkg::CTL_STOP_RX];
	assign auto_en = s_r.ctrl[cct_pkg::CTL_AUTO];
	assign trim = start_mode[1];

	// ****************************************
	// Bus decode
	// ****************************************
	logic [7:0] idx;
	logic aligned;
	logic commit;
	logic wr_lane;

	assign idx = i_avs_address[9:2];
	assign aligned = (i_avs_address[1:0] == 2'h0);
	// Write takes effect on the edge where waitrequest is sampled low
	assign commit = !s_r.bus_wait && i_avs_write && aligned;
	assign wr_lane = commit && i_avs_byteenable[0];

	// Software start and stop pulses from the command register
	logic sw_start;
	logic sw_stop;

	assign sw_start = wr_lane && (idx == cct_pkg::IDX_CMD) &&
		i_avs_writedata[cct_pkg::CMD_START];
	assign sw_stop = wr_lane && (idx == cct_pkg::IDX_CMD) &&
		i_avs_writedata[cct_pkg::CMD_STOP];

	// ****************************************
	// Event logic
	// ****************************************
	logic osc_rise;
	logic tick_sel;
	logic rx_stop;
	logic trim_start;
	logic trim_stop;
	logic start_ev;
	logic stop_ev;
	logic at_zero;
	logic uf_ev;
	logic zero_stop;

	// Rise counts only once the two late stages agree
	assign osc_rise = (s_r.osc_s2 == s_r.osc_s3) && s_r.osc_s3 &&
		!s_r.osc_level;

	// Input clock choice, one enable per counted step
	always_comb begin
		tick_sel = 1'b0;
		case (clk_sel)
			cct_pkg::CLK_FAST: tick_sel = ticks.fast_tick;
			cct_pkg::CLK_SLOW: tick_sel = ticks.slow_tick;
			cct_pkg::CLK_T0: tick_sel = i_t0_underflow;
			default: tick_sel = i_t1_underflow;
		endcase
	end

	// Receive stop is masked off in both trimming modes
	assign rx_stop = s_r.running && stop_rx_en && !trim && i_rx_first4;
	// First oscillator rise starts, the next one stops
	assign trim_start = trim && osc_rise && !s_r.running;
	assign trim_stop = trim && osc_rise && s_r.running;
	assign stop_ev = rx_stop || trim_stop || sw_stop;
	// Stop wins over any start seen in the same cycle
	assign start_ev = !stop_ev && (sw_start || trim_start ||
		((start_mode == cct_pkg::START_TX_END) && i_tx_end));

	assign at_zero = (s_r.count == 16'h0000);
	// Trimming without underflow never wraps and never flags underflow
	assign uf_ev = s_r.running && tick_sel && at_zero && !stop_ev &&
		!start_ev && (start_mode != cct_pkg::START_TRIM);
	assign zero_stop = s_r.running && tick_sel && at_zero && !stop_ev &&
		!start_ev && (!auto_en || (start_mode == cct_pkg::START_TRIM));

	// ****************************************
	// Read mux
	// ****************************************
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (!aligned) begin
			rd_val = 32'h0000_0000;
		end else if (idx == cct_pkg::IDX_CTRL) begin
			rd_val = {24'h00_0000, s_r.ctrl};
		end else if (idx == cct_pkg::IDX_RLD_HI) begin
			rd_val = {24'h00_0000, s_r.reload[15:8]};
		end else if (idx == cct_pkg::IDX_RLD_LO) begin
			rd_val = {24'h00_0000, s_r.reload[7:0]};
		end else if (idx == cct_pkg::IDX_CNT_HI) begin
			rd_val = {24'h00_0000, s_r.count[15:8]};
		end else if (idx == cct_pkg::IDX_CNT_LO) begin
			rd_val = {24'h00_0000, s_r.count[7:0]};
		end else if (idx == cct_pkg::IDX_SIB_CTRL) begin
			rd_val = {24'h00_0000, s_r.sib_ctrl};
		end else if (idx == cct_pkg::IDX_IRQ_STATUS) begin
			rd_val = {30'h0000_0000, s_r.status};
		end else if (idx == cct_pkg::IDX_IRQ_MASK) begin
			rd_val = {30'h0000_0000, s_r.mask};
		end else if (idx == cct_pkg::IDX_RUN) begin
			rd_val = {31'h0000_0000, s_r.running};
		end else begin
			rd_val = 32'h0000_0000;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	logic [cct_pkg::IRQ_W-1:0] irq_set;
	logic [cct_pkg::IRQ_W-1:0] irq_clr;

	always_comb begin
		s_nxt = s_r;
		s_nxt.underflow = 1'b0;
		irq_set = '0;
		irq_clr = '0;

		// Three-stage pin synchroniser with agreement filter
		s_nxt.osc_s1 = i_slow_osc;
		s_nxt.osc_s2 = s_r.osc_s1;
		s_nxt.osc_s3 = s_r.osc_s2;
		if (s_r.osc_s2 == s_r.osc_s3) begin
			s_nxt.osc_level = s_r.osc_s3;
		end

		// Bus handshake: one wait cycle, then one answer cycle
		if ((i_avs_read || i_avs_write) && s_r.bus_wait) begin
			s_nxt.bus_wait = 1'b0;
			s_nxt.rdata = i_avs_read ? rd_val : 32'h0000_0000;
		end else if (!s_r.bus_wait) begin
			s_nxt.bus_wait = 1'b1;
		end

		// Register writes, reserved bits forced to zero
		if (wr_lane) begin
			if (idx == cct_pkg::IDX_CTRL) begin
				s_nxt.ctrl = i_avs_writedata[7:0] & cct_pkg::CTL_WMASK;
			end else if (idx == cct_pkg::IDX_SIB_CTRL) begin
				s_nxt.sib_ctrl = i_avs_writedata[7:0] & cct_pkg::CTL_WMASK;
			end else if (idx == cct_pkg::IDX_RLD_HI) begin
				// Only the reload copy changes, not the live count
				s_nxt.reload[15:8] = i_avs_writedata[7:0];
			end else if (idx == cct_pkg::IDX_RLD_LO) begin
				s_nxt.reload[7:0] = i_avs_writedata[7:0];
			end else if (idx == cct_pkg::IDX_IRQ_STATUS) begin
				irq_clr = i_avs_writedata[cct_pkg::IRQ_W-1:0];
			end else if (idx == cct_pkg::IDX_IRQ_MASK) begin
				s_nxt.mask = i_avs_writedata[cct_pkg::IRQ_W-1:0];
			end
		end

		// Counter: stop, then start, then one step per tick
		if (stop_ev) begin
			s_nxt.running = 1'b0;
		end else if (start_ev) begin
			s_nxt.count = s_r.reload;
			s_nxt.running = 1'b1;
		end else if (s_r.running && tick_sel) begin
			if (!at_zero) begin
				s_nxt.count = s_r.count - 16'h0001;
			end else if (zero_stop) begin
				s_nxt.running = 1'b0;
			end else begin
				s_nxt.count = s_r.reload;
			end
		end

		// Sticky events; a set in the clear cycle survives
		if (uf_ev) begin
			s_nxt.underflow = 1'b1;
			irq_set[cct_pkg::IRQ_UNDERFLOW] = 1'b1;
		end
		if (s_r.running && (stop_ev || zero_stop)) begin
			irq_set[cct_pkg::IRQ_STOPPED] = 1'b1;
		end
		s_nxt.status = (s_r.status & ~irq_clr) | irq_set;
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
	end

	// Register the whole state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_r <= RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_avs_readdata = s_r.rdata;
	assign o_avs_waitrequest = s_r.bus_wait;
	assign o_underflow = s_r.underflow;
	assign o_running = s_r.running;
	assign o_sibling_control = s_r.sib_ctrl;
	assign o_irq = s_r.irq;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_rx_seen;
		s_r.running && stop_rx_en && !trim && i_rx_first4;
	endsequence

	sequence s_trim_rx;
		s_r.running && trim && i_rx_first4 && !osc_rise && !sw_stop &&
			!tick_sel;
	endsequence

	a_rx_halts_timer: assert property (s_rx_seen |=> !o_running)
		else $error("receive stop did not halt timer");

	a_trim_ignores_rx: assert property (s_trim_rx |=> o_running)
		else $error("trimming mode stopped on receive");

	a_tx_end_start: assert property (
		(start_mode == cct_pkg::START_TX_END) && i_tx_end && !stop_ev
		|=> o_running && (s_r.count == $past(s_r.reload)))
		else $error("end of transmission did not load and start");

	a_no_auto_start: assert property (
		(start_mode == cct_pkg::START_NONE) && !s_r.running && !sw_start
		|=> !o_running)
		else $error("timer started with no start source");

	a_trim_edge_start: assert property (
		trim && osc_rise && !s_r.running && !sw_stop
		|=> o_running ##1 o_running)
		else $error("oscillator edge did not start trimming");

	a_auto_reload: assert property (
		uf_ev && auto_en |=> o_running && (s_r.count == $past(s_r.reload)))
		else $error("auto reload did not restart countdown");

	a_oneshot_stop: assert property (
		s_r.running && tick_sel && at_zero && !auto_en && !start_ev
		|=> !o_running)
		else $error("one-shot timer kept running at zero");

	a_underflow_flag: assert property (
		uf_ev |=> s_r.status[cct_pkg::IRQ_UNDERFLOW] && o_underflow
		##1 !o_underflow)
		else $error("underflow flag or pulse wrong");

	a_cascade_hold: assert property (
		s_r.running && (clk_sel == cct_pkg::CLK_T0) && !i_t0_underflow &&
		!start_ev && !stop_ev |=> $stable(s_r.count))
		else $error("cascaded counter moved without underflow");

	a_tick_decrement: assert property (
		s_r.running && tick_sel && !at_zero && !start_ev && !stop_ev
		|=> s_r.count == $past(s_r.count) - 16'h0001)
		else $error("counter did not step once per tick");

	a_reserved_zero: assert property (
		(s_r.ctrl & ~cct_pkg::CTL_WMASK) == 8'h00 &&
		(s_r.sib_ctrl & ~cct_pkg::CTL_WMASK) == 8'h00)
		else $error("reserved control bit set");

	a_bus_one_wait: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer not one cycle after request");

endmodule

// >>> test_cascadable_countdown_timer.sv
`timescale 1ns/100ps
module test_cascadable_countdown_timer;

	// ****************************************
	// Stimulus, outputs and model state
	// ****************************************
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [9:0] adr = 10'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hf;
	logic [3:0] ev_v = 4'h0;
	logic osc = 1'b0;
	logic [31:0] rdat;
	logic [31:0] rv;
	logic wait_rq;
	logic uf;
	logic running;
	logic irq;
	logic [7:0] sib;
	int error_cnt = 0;
	int compares = 0;
	int seed = 66119;
	int cyc = 0;
	int uf_n = 0;
	int m_cnt, m_rld, m_stat, m_ufn, n;
	bit m_run, m_auto;
	// Expected live counts, one per model step, taken in order
	int exp_q[$];

	cct_timer cct_timer_i (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_avs_address(adr),
		.i_avs_read(rd),
		.i_avs_write(wr),
		.i_avs_writedata(wd),
		.i_avs_byteenable(be),
		.o_avs_readdata(rdat),
		.o_avs_waitrequest(wait_rq),
		.i_tx_end(ev_v[3]),
		.i_rx_first4(ev_v[2]),
		.i_t0_underflow(ev_v[1]),
		.i_t1_underflow(ev_v[0]),
		.i_slow_osc(osc),
		.o_underflow(uf),
		.o_running(running),
		.o_sibling_control(sib),
		.o_irq(irq)
	);

	// Free-running clock
	initial begin
		forever #5 i_clk = ~i_clk;
	end

	// Hang guard and underflow pulse counter
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (uf === 1'b1) uf_n <= uf_n + 1;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict;
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Holds the request until waitrequest is sampled low
	// Waits for the answer; only the hang guard ends a wait
	task bus(input bit w, input logic [9:0] a, input logic [7:0] d);
		@(posedge i_clk);
		adr <= a;
		wd <= {24'h0, d};
		rd <= !w;
		wr <= w;
		do begin
			@(posedge i_clk);
		end while (wait_rq !== 1'b0);
		rv = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task wreg(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, {idx, 2'b00}, d);
	endtask

	task rchk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, {idx, 2'b00}, 8'h00);
		chk(rv, {24'h0, exp});
	endtask

	// One-cycle event pulse, then let the answer land
	task ev(input logic [3:0] v);
		@(posedge i_clk);
		ev_v <= v;
		@(posedge i_clk);
		ev_v <= 4'h0;
		@(posedge i_clk);
		#1;
	endtask

	// Slow oscillator level; the synchroniser needs a few cycles
	task set_osc(input logic v);
		@(posedge i_clk);
		osc <= v;
		repeat (8) @(posedge i_clk);
		#1;
	endtask

	// Model step for one selected input tick
	task tick;
		if (m_run) begin
			if (m_cnt == 0) begin
				m_ufn++;
				m_stat |= 1;
				if (m_auto) m_cnt = m_rld;
				else begin
					m_run = 0;
					m_stat |= 2;
				end
			end else begin
				m_cnt--;
			end
		end
		exp_q.push_back(m_cnt);
	endtask

	task print_verdict;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		m_ufn = 0;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		// Reset values, misaligned, unmapped and byte-enable refusals
		rchk(cct_pkg::IDX_CTRL, 8'h00);
		rchk(cct_pkg::IDX_CNT_HI, 8'h00);
		bus(1'b1, 10'h065, 8'hff);
		be <= 4'he;
		wreg(cct_pkg::IDX_CTRL, 8'hff);
		be <= 4'hf;
		rchk(cct_pkg::IDX_CTRL, 8'h00);
		rchk(8'hff, 8'h00);
		wreg(cct_pkg::IDX_CTRL, 8'hff);
		rchk(cct_pkg::IDX_CTRL, 8'hbb);
		wreg(cct_pkg::IDX_SIB_CTRL, 8'hff);
		rchk(cct_pkg::IDX_SIB_CTRL, 8'hbb);
		chk(sib, 8'hbb);
		// Cascaded counting, both sources, with and without reload
		for (int k = 0; k < 4; k++) begin
			m_auto = k[0];
			m_rld = 2 + ($random(seed) & 3);
			wreg(cct_pkg::IDX_RLD_HI, 8'h00);
			wreg(cct_pkg::IDX_RLD_LO, m_rld[7:0]);
			wreg(cct_pkg::IDX_CTRL, {4'h0, m_auto, 1'b0, 1'b1, k[1]});
			wreg(cct_pkg::IDX_IRQ_MASK, 8'h01);
			wreg(cct_pkg::IDX_IRQ_STATUS, 8'h03);
			wreg(cct_pkg::IDX_CMD, 8'h01);
			m_cnt = m_rld;
			m_run = 1;
			m_stat = 0;
			rchk(cct_pkg::IDX_CNT_LO, m_cnt[7:0]);
			if (k == 0) begin
				wreg(cct_pkg::IDX_RLD_HI, 8'ha5);
				wreg(cct_pkg::IDX_RLD_LO, 8'h7f);
			end
			for (int j = 0; j < m_rld + 3; j++) begin
				ev(k[1] ? 4'h1 : 4'h2);
				tick;
				ev(k[1] ? 4'h2 : 4'h1);
				// Count read only between pulses, never in reception
				rchk(cct_pkg::IDX_CNT_LO, 8'(exp_q.pop_front()));
				chk(running, m_run);
			end
			chk(uf_n, m_ufn);
			rchk(cct_pkg::IDX_IRQ_STATUS, m_stat[7:0]);
			chk(irq, m_stat[0]);
			if (k == 0) begin
				wreg(cct_pkg::IDX_CMD, 8'h01);
				rchk(cct_pkg::IDX_CNT_HI, 8'ha5);
				rchk(cct_pkg::IDX_CNT_LO, 8'h7f);
			end
			wreg(cct_pkg::IDX_CMD, 8'h02);
			wreg(cct_pkg::IDX_IRQ_STATUS, 8'h03);
			#1;
			chk(irq, 1'b0);
		end
		// Start sources and stop on receive, cascade clock held still
		wreg(cct_pkg::IDX_RLD_LO, 8'h05);
		wreg(cct_pkg::IDX_CTRL, 8'h82);
		ev(4'h8);
		chk(running, 1'b0);
		wreg(cct_pkg::IDX_CTRL, 8'h12);
		ev(4'h8);
		chk(running, 1'b1);
		ev(4'h4);
		chk(running, 1'b1);
		wreg(cct_pkg::IDX_CTRL, 8'h92);
		ev(4'h4);
		chk(running, 1'b0);
		// Trimming: oscillator rises start and stop, receive ignored
		wreg(cct_pkg::IDX_CTRL, 8'ha2);
		set_osc(1'b1);
		chk(running, 1'b1);
		ev(4'h4);
		chk(running, 1'b1);
		set_osc(1'b0);
		set_osc(1'b1);
		chk(running, 1'b0);
		set_osc(1'b0);
		// Trimming to zero: underflow only in the code that includes it
		for (int m = 2; m < 4; m++) begin
			wreg(cct_pkg::IDX_RLD_LO, 8'h01);
			wreg(cct_pkg::IDX_CTRL, {2'b00, m[1:0], 4'h2});
			wreg(cct_pkg::IDX_IRQ_STATUS, 8'h03);
			m_ufn += m[0];
			set_osc(1'b1);
			chk(running, 1'b1);
			ev(4'h2);
			ev(4'h2);
			chk(running, 1'b0);
			chk(uf_n, m_ufn);
			rchk(cct_pkg::IDX_IRQ_STATUS, {6'h00, 1'b1, m[0]});
			set_osc(1'b0);
		end
		// Fixed ticks: time to underflow lies within jitter bounds
		for (int c = 0; c < 2; c++) begin
			wreg(cct_pkg::IDX_RLD_LO, c ? 8'h01 : 8'h10);
			wreg(cct_pkg::IDX_CTRL, {7'h00, c[0]});
			wreg(cct_pkg::IDX_CMD, 8'h01);
			@(posedge i_clk);
			#1;
			n = 0;
			while (running === 1'b1 && n < 2000) begin
				@(posedge i_clk);
				n++;
			end
			chk(c ? (n >= 460 && n <= 960) : (n >= 112 && n <= 136), 1);
		end
		print_verdict;
	end

endmodule
